/* common/iscf_pkg.sv */
// package: register map, field positions, reset values and states for the scl/status block
package iscf_pkg;
  // register byte offsets
  localparam logic [5:0] OFF_STATUS2 = 6'h18;
  localparam logic [5:0] OFF_CLKCTRL = 6'h1c;
  localparam logic [5:0] OFF_RISE = 6'h20;
  localparam logic [5:0] OFF_FILTER = 6'h24;
  localparam logic [5:0] OFF_IRQ_STAT = 6'h28;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h2c;
  // status field positions
  localparam int BIT_MASTER = 0;
  localparam int BIT_BUSY = 1;
  localparam int BIT_TX = 2;
  localparam int BIT_GCALL = 4;
  localparam int BIT_SMBDEF = 5;
  localparam int BIT_HOSTHDR = 6;
  localparam int BIT_DUAL = 7;
  localparam int BIT_PEC_LO = 8;
  // clock control and filter register fields
  localparam int BIT_DUTY = 14;
  localparam int BIT_SPEED = 15;
  localparam int BIT_ANF_OFF = 4;
  // reset values
  localparam logic [15:0] RST_CLKCTRL = 16'h0000;
  localparam logic [5:0] RST_RISE = 6'h02;
  localparam logic [4:0] RST_FILTER = 5'h00;
  // fast-mode duty multipliers
  localparam logic [4:0] MUL_FAST16_HI = 5'h09;
  localparam logic [4:0] MUL_FAST16_LO = 5'h10;
  // interrupt event bits
  localparam int IRQ_BUSY_RISE = 0;
  localparam int IRQ_ARB_LOST = 1;
  localparam int IRQ_ADDR_HIT = 2;
  localparam int IRQ_W = 3;
  // bus slave answer states
  typedef enum logic [1:0] {
    ISCF_IDLE = 2'b00,
    ISCF_ACK = 2'b01
  } iscf_bus_st_t;
endpackage

/* dv/iscf_bus_partner.sv */
// far-side bus party: pull-ups, wired-and lines, remote master clocking
`timescale 1ns/1ps
`default_nettype none
module iscf_bus_partner (
  input wire logic scl_oe,
  input wire logic run,
  input wire logic pull_sda,
  output logic scl_line,
  output logic sda_line
);
  logic rclk; // remote clock, stands high outside frames
  // 32 ns remote clock only while a frame runs
  initial begin
    rclk = 1'b1;
    forever begin
      #16;
      rclk = run ? ~rclk : 1'b1;
    end
  end
  // released lines rise through the pull-ups
  assign scl_line = rclk & ~scl_oe;
  assign sda_line = ~pull_sda;
endmodule
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the scl/status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst_b, rd, wr, wt, irq, pen, arp, pce, smb, rwb, run, psda;
  logic scl_oe, scl_filt, anf, scl_line, sda_line, sdaf, sclo;
  logic [8:0] pv; // event pulses
  logic [5:0] adr, rtl;
  logic [7:0] pec;
  logic [31:0] wd, rdat, got, ex;
  int errors, total_checks, n, p, c, hi, lo, i;
  int evq[$] = '{32'h020, 32'h040, 32'h080, 32'h110}; // match events
  int bq[$] = '{32'h10, 32'h20, 32'h40, 32'h84}; // status bits they set
  int mh[4] = '{1, 1, 9, 1};
  int ml[4] = '{1, 2, 16, 1};
  logic [15:0] cc[4] = '{16'h0000, 16'h8000, 16'hc000, 16'hc000};
  iscf_top uut (.clk, .rst_b, .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'b0011), .avs_readdata(rdat),
    .avs_waitrequest(wt), .irq, .peripheral_enable(pen),
    .address_resolution_enable(arp), .smbus_host_type_select(1'b1),
    .packet_check_enable(pce), .smbus_mode(smb), .master_start(pv[0]),
    .stop_done(pv[1]), .restart_done(pv[2]), .arb_lost(pv[3]), .addr_rw_valid(pv[4]),
    .addr_rw_bit(rwb), .broadcast_addr_match(pv[5]), .smbus_default_addr_match(pv[6]),
    .smbus_host_header_match(pv[7]), .second_own_addr_match(pv[8]),
    .packet_check_calc(pec), .scl_in(scl_line), .sda_in(sda_line), .scl_out(sclo),
    .scl_oe, .scl_filt, .sda_filt(sdaf), .analog_glitch_filter_off(anf),
    .rise_time_limit(rtl));
  iscf_bus_partner far_end (.scl_oe, .run, .pull_sda(psda), .scl_line, .sda_line);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic give_verdict;
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one avalon access, held until waitrequest low
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (wt === 1'b0) break;
    end
    if (k == 50) begin
      errors++;
      give_verdict();
    end
    got = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic ev(input logic [8:0] m);
    pv <= m;
    @(posedge clk);
    pv <= '0;
    repeat (2) @(posedge clk);
  endtask
  // length of a run of scl_oe at level v
  task automatic phase(input logic v, output int c);
    c = 0;
    while (scl_oe === v && c < 400) begin
      @(negedge clk);
      c++;
    end
    if (c >= 400) begin
      errors++;
      give_verdict();
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    void'($urandom(83759));
    {rst_b, rd, wr, adr, wd, pv, smb, pce, pec, run, psda, rwb} = '0;
    {pen, arp} = 2'b11;
    errors = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // reset values
    acc(0, iscf_pkg::OFF_CLKCTRL, 0); chk(got, 32'h0000_0000);
    acc(0, iscf_pkg::OFF_RISE, 0); chk(got, 32'h0000_0002);
    acc(0, iscf_pkg::OFF_FILTER, 0); chk(got, 32'h0000_0000);
    acc(0, iscf_pkg::OFF_STATUS2, 0); chk(got, 32'h0000_0000);
    n = $urandom_range(63);
    acc(1, iscf_pkg::OFF_RISE, n);
    acc(0, iscf_pkg::OFF_RISE, 0); chk(got, n);
    chk(rtl, n);
    acc(1, iscf_pkg::OFF_CLKCTRL, 32'h0000_ffff);
    acc(0, iscf_pkg::OFF_CLKCTRL, 0); chk(got, 32'h0000_cfff);
    acc(1, 6'h30, 32'h0000_ffff);
    acc(0, 6'h30, 0); chk(got, 32'h0000_0000);
    // filter length refused while disabled
    pen <= 1'b0;
    acc(1, iscf_pkg::OFF_FILTER, 32'h0000_001f);
    acc(0, iscf_pkg::OFF_FILTER, 0); chk(got, 32'h0000_0010);
    chk(anf, 1'b1);
    pen <= 1'b1;
    acc(1, iscf_pkg::OFF_FILTER, 32'h0000_000f);
    acc(0, iscf_pkg::OFF_FILTER, 0); chk(got, 32'h0000_000f);
    chk(anf, 1'b0);
    acc(1, iscf_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    // 4-cycle remote pulses hidden by a 15-cycle filter
    run <= 1'b1;
    n = 0;
    repeat (200) @(negedge clk) if (scl_filt !== 1'b1) n++;
    chk(n, 0);
    acc(1, iscf_pkg::OFF_FILTER, 0);
    n = 0;
    repeat (200) @(negedge clk) if (scl_filt !== 1'b1) n++;
    @(posedge clk);
    run <= 1'b0;
    chk(n > 0, 1'b1);
    acc(0, iscf_pkg::OFF_STATUS2, 0); chk(got[1], 1'b1);
    @(negedge clk); chk(irq, 1'b1);
    acc(1, iscf_pkg::OFF_IRQ_MASK, 0);
    @(negedge clk); chk(irq, 1'b0);
    // data line held low keeps busy through a stop
    psda <= 1'b1;
    repeat (10) @(posedge clk);
    chk(sdaf, 1'b0);
    chk(sclo, 1'b0);
    ev(9'h002);
    acc(0, iscf_pkg::OFF_STATUS2, 0); chk(got[1], 1'b1);
    psda <= 1'b0;
    repeat (10) @(posedge clk);
    ev(9'h002);
    acc(1, iscf_pkg::OFF_IRQ_STAT, 32'h0000_0001);
    acc(1, iscf_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    acc(0, iscf_pkg::OFF_STATUS2, 0); chk(got, 0);
    @(negedge clk); chk(irq, 1'b0);
    // slave flags accumulate, restart and stop clear them
    rwb <= 1'b1;
    ev(9'h010);
    acc(0, iscf_pkg::OFF_STATUS2, 0); chk(got, 32'h0000_0004);
    ev(9'h004);
    acc(0, iscf_pkg::OFF_STATUS2, 0); chk(got, 0);
    ex = 0;
    foreach (evq[k]) begin
      ev(evq[k]);
      ex |= bq[k];
      acc(0, iscf_pkg::OFF_STATUS2, 0); chk(got, ex);
    end
    ev(9'h002);
    acc(0, iscf_pkg::OFF_STATUS2, 0); chk(got, 0);
    arp <= 1'b0;
    ev(9'h0c0);
    acc(0, iscf_pkg::OFF_STATUS2, 0); chk(got, 0);
    ev(9'h130);
    pen <= 1'b0;
    repeat (2) @(posedge clk);
    pen <= 1'b1;
    acc(0, iscf_pkg::OFF_STATUS2, 0); chk(got, 0);
    pec <= 8'($urandom());
    pce <= 1'b1;
    repeat (3) @(posedge clk);
    acc(0, iscf_pkg::OFF_STATUS2, 0); chk(got[15:8], pec);
    pce <= 1'b0;
    // scl phases for each speed and duty setting
    p = $urandom_range(5, 2);
    for (i = 0; i < 4; i++) begin
      smb <= (i == 3);
      acc(1, iscf_pkg::OFF_CLKCTRL, {16'h0000, cc[i] | 16'(p)});
      ev(9'h001);
      acc(0, iscf_pkg::OFF_STATUS2, 0); chk(got[0], 1'b1);
      phase(1, c);
      phase(0, c);
      phase(1, lo);
      phase(0, hi);
      chk(lo, ml[i] * p);
      chk(hi, mh[i] * p);
      ev(i[0] ? 9'h008 : 9'h002);
      acc(0, iscf_pkg::OFF_STATUS2, 0); chk(got[0], 1'b0);
    end
    give_verdict();
  end
endmodule
`default_nettype wire

/* rtl/iscf_top.sv */
// scl generator, second status register, filters and avalon slave
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - master flag set as master, cleared stop/arb/disable
// - busy flag on low line, cleared on stop
// - transmitter flag from r/w bit, cleared
// - broadcast hit flag in slave mode
// - smbus default address hit when resolution enabled
// - host header hit when host type, resolution
// - second own address hit flag in slave
// - packet check byte shown when enabled
// - standard mode: equal high and low periods
// - fast duty zero: low twice high
// - fast duty one: high 9, low 16
// - speed bit selects standard or fast outside smbus mode; smbus mode keeps equal phases
// - six bit rise limit, resets to two
// - digital filter length, writable only enabled
// - analog filter bit: zero on, one bypass
// - arbitration loss returns to slave operation
module iscf_top (
  input wire logic clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  // control from the rest of the controller
  input wire logic peripheral_enable,
  input wire logic address_resolution_enable,
  input wire logic smbus_host_type_select,
  input wire logic packet_check_enable,
  input wire logic smbus_mode,
  input wire logic master_start,
  input wire logic stop_done,
  input wire logic restart_done,
  input wire logic arb_lost,
  input wire logic addr_rw_valid,
  input wire logic addr_rw_bit,
  input wire logic broadcast_addr_match,
  input wire logic smbus_default_addr_match,
  input wire logic smbus_host_header_match,
  input wire logic second_own_addr_match,
  input wire logic [7:0] packet_check_calc,
  // bus pins (from outside the clock domain)
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  // filtered lines and filter settings for the engine
  output logic scl_filt,
  output logic sda_filt,
  output logic analog_glitch_filter_off,
  output logic [5:0] rise_time_limit
);
  // --- registers
  logic [15:0] clkctrl_q; // period, duty, speed
  logic [5:0] rise_q; // rise time limit
  logic [3:0] dnf_q; // digital filter length
  logic anf_off_q; // analog filter bypass
  logic master_q, busy_q, tx_q, gcall_q, smbdef_q, hosthdr_q, dual_q;
  logic [7:0] pec_q; // packet check byte
  localparam int IRQ_W_L = iscf_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] ist_q, imask_q;
  // --- synchronisers: first stage read only by second
  logic [1:0] scl_s_q, sda_s_q;
  logic [3:0] scl_cnt_q, sda_cnt_q; // glitch filter counters
  logic scl_f_q, sda_f_q; // filtered line levels
  logic scl_o_q; // scl drive level
  logic [16:0] ph_cnt_q; // phase counter
  logic busy_prev_q;
  iscf_pkg::iscf_bus_st_t bus_q;
  logic [31:0] rdata_q;

  // clock-control fields
  wire [11:0] scl_period_setting = clkctrl_q[11:0];
  wire fast_duty_select = clkctrl_q[iscf_pkg::BIT_DUTY];
  wire speed_select = clkctrl_q[iscf_pkg::BIT_SPEED];

  // period product: setting times a small multiplier
  function automatic logic [16:0] scale(input logic [11:0] s, input logic [4:0] m);
    // widen first so 16 times a large setting keeps its top bits
    scale = 17'(s) * 17'(m);
  endfunction

  // standard or smbus mode keeps equal phases
  // fast, duty zero: low twice the high
  // fast, duty one: 9 high, 16 low
  // speed select picks the timing set
  wire fast_sel = speed_select & ~smbus_mode;
  wire [16:0] hi_len = !fast_sel ? scale(scl_period_setting, 5'h01) :
    (fast_duty_select ? scale(scl_period_setting, iscf_pkg::MUL_FAST16_HI) :
     scale(scl_period_setting, 5'h01));
  wire [16:0] lo_len = !fast_sel ? scale(scl_period_setting, 5'h01) :
    (fast_duty_select ? scale(scl_period_setting, iscf_pkg::MUL_FAST16_LO) :
     scale(scl_period_setting, 5'h02));

  // bus decode
  wire sel_clk = avs_address == iscf_pkg::OFF_CLKCTRL;
  wire sel_rise = avs_address == iscf_pkg::OFF_RISE;
  wire sel_filt = avs_address == iscf_pkg::OFF_FILTER;
  wire sel_ist = avs_address == iscf_pkg::OFF_IRQ_STAT;
  wire sel_imask = avs_address == iscf_pkg::OFF_IRQ_MASK;
  wire sel_st2 = avs_address == iscf_pkg::OFF_STATUS2;
  wire req = (avs_read | avs_write) & (bus_q == iscf_pkg::ISCF_IDLE);
  // write lands at the answer edge, when the master sees waitrequest low
  wire wr = avs_write & (bus_q == iscf_pkg::ISCF_ACK);
  wire [15:0] wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [15:0] st2 = {pec_q, dual_q, hosthdr_q, smbdef_q, gcall_q, 1'b0, tx_q, busy_q, master_q};

  // read data mux
  wire [31:0] rmux = sel_st2 ? {16'h0000, st2} :
    sel_clk ? {16'h0000, clkctrl_q & 16'hcfff} :
    sel_rise ? {26'h000_0000, rise_q} :
    sel_filt ? {27'h000_0000, anf_off_q, dnf_q} :
    sel_ist ? {29'h0000_0000, ist_q} :
    sel_imask ? {29'h0000_0000, imask_q} : 32'h0000_0000;

  // line events from filtered levels
  wire line_low = ~scl_f_q | ~sda_f_q;
  wire en_off = ~peripheral_enable;
  wire flag_clr = stop_done | restart_done | en_off;

  // avalon answer: one wait cycle, answer on the next edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus_q <= iscf_pkg::ISCF_IDLE;
      rdata_q <= 32'h0000_0000;
    end else begin
      case (bus_q)
        iscf_pkg::ISCF_IDLE: begin
          if (req) begin
            bus_q <= iscf_pkg::ISCF_ACK;
            rdata_q <= rmux;
          end
        end
        iscf_pkg::ISCF_ACK: bus_q <= iscf_pkg::ISCF_IDLE;
        default: bus_q <= iscf_pkg::ISCF_IDLE;
      endcase
    end
  end
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = (bus_q != iscf_pkg::ISCF_ACK);

  // writable configuration registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      clkctrl_q <= iscf_pkg::RST_CLKCTRL;
      rise_q <= iscf_pkg::RST_RISE;
      dnf_q <= 4'h0;
      anf_off_q <= 1'b0;
      imask_q <= '0;
    end else if (wr) begin
      // reserved bits 13:12 never stored
      if (sel_clk) clkctrl_q <= ((avs_writedata[15:0] & wmask) | (clkctrl_q & ~wmask)) & 16'hcfff;
      if (sel_rise && avs_byteenable[0]) rise_q <= avs_writedata[5:0];
      if (sel_filt && avs_byteenable[0] && peripheral_enable) dnf_q <= avs_writedata[3:0];
      if (sel_filt && avs_byteenable[0]) anf_off_q <= avs_writedata[iscf_pkg::BIT_ANF_OFF];
      if (sel_imask && avs_byteenable[0]) imask_q <= avs_writedata[IRQ_W_L-1:0];
    end
  end

  // two-flop synchronisers for the bus lines
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
    end
  end

  // digital glitch filter: level must persist beyond n cycles
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_cnt_q <= 4'h0;
      sda_cnt_q <= 4'h0;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      if (scl_s_q[1] == scl_f_q) scl_cnt_q <= 4'h0;
      else if (scl_cnt_q >= dnf_q) begin
        scl_f_q <= scl_s_q[1];
        scl_cnt_q <= 4'h0;
      end else scl_cnt_q <= scl_cnt_q + 4'h1;
      if (sda_s_q[1] == sda_f_q) sda_cnt_q <= 4'h0;
      else if (sda_cnt_q >= dnf_q) begin
        sda_f_q <= sda_s_q[1];
        sda_cnt_q <= 4'h0;
      end else sda_cnt_q <= sda_cnt_q + 4'h1;
    end
  end

  // role and direction flags
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      master_q <= 1'b0;
      busy_q <= 1'b0;
      tx_q <= 1'b0;
    end else begin
      // master set on start, cleared stop/arb/disable
      // arbitration loss drops back to slave
      if (stop_done | arb_lost | en_off) master_q <= 1'b0;
      else if (master_start) master_q <= 1'b1;
      // busy on any low line; stop releases, low level wins
      if (line_low) busy_q <= 1'b1;
      else if (stop_done) busy_q <= 1'b0;
      // transmitter flag follows the r/w bit
      if (flag_clr | arb_lost) tx_q <= 1'b0;
      else if (addr_rw_valid) tx_q <= addr_rw_bit;
    end
  end

  // slave address-match flags
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gcall_q <= 1'b0;
      smbdef_q <= 1'b0;
      hosthdr_q <= 1'b0;
      dual_q <= 1'b0;
    end else begin
      if (flag_clr) gcall_q <= 1'b0;
      else if (broadcast_addr_match & ~master_q) gcall_q <= 1'b1;
      if (flag_clr) smbdef_q <= 1'b0;
      else if (smbus_default_addr_match & address_resolution_enable & ~master_q)
        smbdef_q <= 1'b1;
      // host header when host type and resolution
      if (flag_clr) hosthdr_q <= 1'b0;
      else if (smbus_host_header_match & smbus_host_type_select &
               address_resolution_enable & ~master_q)
        hosthdr_q <= 1'b1;
      if (flag_clr) dual_q <= 1'b0;
      else if (addr_rw_valid & ~master_q) dual_q <= second_own_addr_match;
    end
  end

  // packet check byte captured while enabled
  always_ff @(posedge clk) begin
    if (!rst_b) pec_q <= 8'h00;
    else if (packet_check_enable) pec_q <= packet_check_calc;
  end

  // scl phase counter, reloads at every scl edge while master
  wire ph_done = (ph_cnt_q <= 17'h0_0001);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_o_q <= 1'b1;
      ph_cnt_q <= 17'h0_0000;
    end else if (!master_q) begin
      scl_o_q <= 1'b1;
      ph_cnt_q <= hi_len;
    end else if (ph_done) begin
      scl_o_q <= ~scl_o_q;
      ph_cnt_q <= scl_o_q ? lo_len : hi_len;
    end else begin
      ph_cnt_q <= ph_cnt_q - 17'h0_0001;
    end
  end

  // interrupt events: set wins over write-one-clear
  wire [IRQ_W_L-1:0] ev = {broadcast_addr_match | second_own_addr_match, arb_lost & master_q,
                           busy_q & ~busy_prev_q};
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ist_q <= '0;
      busy_prev_q <= 1'b0;
    end else begin
      busy_prev_q <= busy_q;
      ist_q <= (ist_q & ~((wr & sel_ist) ? avs_writedata[IRQ_W_L-1:0] : '0)) | ev;
    end
  end

  // registered outputs; scl_out tied low
  logic irq_q;
  always_ff @(posedge clk) begin
    if (!rst_b) irq_q <= 1'b0;
    else irq_q <= |(ist_q & imask_q);
  end
  assign irq = irq_q;
  assign scl_out = 1'b0;
  assign scl_oe = ~scl_o_q;
  assign scl_filt = scl_f_q;
  assign sda_filt = sda_f_q;
  assign analog_glitch_filter_off = anf_off_q;
  assign rise_time_limit = rise_q;

  // assertions
  property master_clr_p;
    @(posedge clk) disable iff (!rst_b) (arb_lost | stop_done) |=> !master_q;
  endproperty
  master_clear_a: assert property (master_clr_p) else $error("master flag not cleared");
  arb_slave_a: assert property (@(posedge clk) disable iff (!rst_b)
    arb_lost |=> !master_q ##1 scl_oe == 1'b0) else $error("not back to slave");
  busy_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    line_low |=> busy_q) else $error("busy not set");
  tx_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (stop_done | restart_done | arb_lost) |=> !tx_q) else $error("tx flag kept");
  gcall_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    (broadcast_addr_match & !master_q & !flag_clr) |=> gcall_q) else $error("gcall lost");
  smbdef_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    !address_resolution_enable & !$past(smbdef_q) |-> !smbdef_q) else $error("smbdef");
  host_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(hosthdr_q) |-> $past(smbus_host_type_select)) else $error("host hdr");
  dual_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    en_off |=> !dual_q) else $error("dual flag kept");
  pec_cap_a: assert property (@(posedge clk) disable iff (!rst_b)
    packet_check_enable |=> pec_q == $past(packet_check_calc)) else $error("pec");
  sequence hi_phase_s;
    $fell(scl_oe) ##0 master_q;
  endsequence
  phase_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    hi_phase_s |-> ph_cnt_q == $past(hi_len)) else $error("phase reload");
  rise_rst_a: assert property (@(posedge clk) $rose(rst_b) |-> rise_q == 6'h02)
    else $error("rise reset");
  dnf_lock_a: assert property (@(posedge clk) disable iff (!rst_b)
    !peripheral_enable |=> dnf_q == $past(dnf_q)) else $error("filter written");
  anf_out_a: assert property (@(posedge clk) disable iff (!rst_b)
    analog_glitch_filter_off == anf_off_q) else $error("anf");
  std_equal_a: assert property (@(posedge clk) disable iff (!rst_b)
    !speed_select |-> hi_len == lo_len) else $error("std unequal");
  fast2_a: assert property (@(posedge clk) disable iff (!rst_b)
    speed_select & !smbus_mode & !fast_duty_select |-> lo_len == 17'(2 * hi_len))
    else $error("fast duty 2");
  fast16_a: assert property (@(posedge clk) disable iff (!rst_b)
    fast_sel & fast_duty_select |-> 17'(9 * lo_len) == 17'(16 * hi_len))
    else $error("fast 16/9");
  speed_sel_a: assert property (@(posedge clk) disable iff (!rst_b)
    fast_sel |-> fast_duty_select | lo_len != hi_len | scl_period_setting == 12'h000)
    else $error("speed");
endmodule
`default_nettype wire
